// ### ctx_cop_model.sv
// Coprocessor units 1 to 3 with data and control banks, and their condition lines.
// Assumes move-from data is read in the cycle the executor takes the issue.
module ctx_cop_model (
  input wire logic clock,
  input wire logic [31:0] issue_instr,
  input wire logic cop_valid,
  input wire logic [1:0] cop_unit,
  input wire logic cop_write,
  input wire logic cop_ctrl,
  input wire logic [4:0] cop_reg,
  input wire logic [31:0] cop_wdata,
  input wire logic [3:0] cond_set,
  output logic [3:0] branch_condition_inputs,
  output logic [31:0] cop_rdata
);
  // Unwritten registers read unknown, as real units give no promise
  logic [31:0] regs [0:255];
  always_ff @(posedge clock) begin
    if (cop_valid && cop_write) begin
      regs[{cop_unit, cop_ctrl, cop_reg}] <= cop_wdata;
    end
  end
  assign cop_rdata = regs[{issue_instr[27:26], issue_instr[22], issue_instr[15:11]}];
  assign branch_condition_inputs = cond_set;
endmodule

// ### ctx_exec.sv
// Executes trap, coprocessor and system-control instructions for the integer pipeline.
// Assumes issue_valid with a 32-bit instruction and its operands, one per cycle.
module ctx_exec (
  input wire logic clock,
  input wire logic reset,
  input wire logic issue_valid,
  input wire logic [ctx_pkg::XW-1:0] issue_instr,
  input wire logic [ctx_pkg::XW-1:0] issue_pc,
  input wire logic [ctx_pkg::XW-1:0] rs_value,
  input wire logic [ctx_pkg::XW-1:0] rt_value,
  input wire logic [3:0] branch_condition_inputs,
  input wire logic [ctx_pkg::XW-1:0] cop_rdata,
  output logic trap_valid,
  output ctx_pkg::ctx_trap_e trap_kind,
  output logic [ctx_pkg::XW-1:0] trap_epc,
  output logic branch_taken,
  output logic [ctx_pkg::XW-1:0] branch_target,
  output logic gpr_we,
  output logic [4:0] gpr_waddr,
  output logic [ctx_pkg::XW-1:0] gpr_wdata,
  output logic mem_read,
  output logic mem_write,
  output logic [ctx_pkg::XW-1:0] mem_addr,
  output logic [4:0] mem_cop_reg,
  output logic [1:0] mem_unit,
  output logic cop_valid,
  output logic [1:0] cop_unit,
  output logic cop_write,
  output logic cop_ctrl,
  output logic cop_func,
  output logic [4:0] cop_reg,
  output logic [ctx_pkg::XW-1:0] cop_wdata,
  output logic [ctx_pkg::COFUN_W-1:0] cop_cofun,
  output logic [ctx_pkg::XW-1:0] status
);
  import ctx_pkg::*;

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  logic [5:0] opc;
  logic [4:0] rs_f;
  logic [4:0] rt_f;
  logic [4:0] rd_f;
  logic [5:0] fn_f;
  logic [1:0] unit;
  logic [XW-1:0] simm;
  logic [XW-1:0] boff;
  logic is_special;
  logic is_cop;
  logic is_lwc;
  logic is_swc;
  logic is_sys;
  logic is_brk;
  logic is_bc;
  logic squash;
  logic go;

  assign opc = issue_instr[OP_HI:OP_LO];
  assign rs_f = issue_instr[RS_HI:RS_LO];
  assign rt_f = issue_instr[RT_HI:RT_LO];
  assign rd_f = issue_instr[RD_HI:RD_LO];
  assign fn_f = issue_instr[FN_HI:FN_LO];
  assign unit = issue_instr[UNIT_HI:UNIT_LO];
  assign simm = {{(XW-IMM_W){issue_instr[IMM_W-1]}}, issue_instr[IMM_W-1:0]};
  assign boff = {simm[XW-3:0], 2'b00};
  assign is_special = (opc == OP_SPECIAL);
  assign is_cop = (opc[5:2] == OP_COP_HI);
  assign is_lwc = (opc[5:2] == OP_LWC_HI);
  assign is_swc = (opc[5:2] == OP_SWC_HI);
  assign is_sys = is_special && (fn_f == FN_OS_SERVICE_TRAP_INSTR);
  assign is_brk = is_special && (fn_f == FN_BREAK);
  assign is_bc = is_cop && (rs_f == RS_BC);

  // One instruction after a trap is the one already issued behind it; drop it
  assign go = issue_valid && !squash;

  // ----------------------------------------------------------------
  // Traps
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      trap_valid <= 1'b0;
      trap_kind <= CTX_TRAP_NONE;
      trap_epc <= '0;
    end else begin
      trap_valid <= go && (is_sys || is_brk);
      trap_kind <= !go ? CTX_TRAP_NONE :
                   is_sys ? CTX_TRAP_OS_SERVICE_TRAP_INSTR :
                   is_brk ? CTX_TRAP_BREAK : CTX_TRAP_NONE;
      if (go && (is_sys || is_brk)) begin
        trap_epc <= issue_pc;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      squash <= 1'b0;
    end else begin
      squash <= go && (is_sys || is_brk);
    end
  end

  // ----------------------------------------------------------------
  // Condition-line branches
  // ----------------------------------------------------------------
  // The lines are chip pins; a level counts only once the last two stages agree,
  // which costs four cycles before a branch can see a new level
  logic [3:0] cond_s1;
  logic [3:0] cond_s2;
  logic [3:0] cond_s3;
  logic [3:0] cond_lvl;
  logic cond_now;

  always_ff @(posedge clock) begin
    if (reset) begin
      cond_s1 <= '0;
      cond_s2 <= '0;
      cond_s3 <= '0;
      cond_lvl <= '0;
    end else begin
      cond_s1 <= branch_condition_inputs;
      cond_s2 <= cond_s1;
      cond_s3 <= cond_s2;
      cond_lvl <= (cond_s2 & cond_s3) | (cond_lvl & (cond_s2 ^ cond_s3));
    end
  end

  assign cond_now = cond_lvl[unit];

  always_ff @(posedge clock) begin
    if (reset) begin
      branch_taken <= 1'b0;
      branch_target <= '0;
    end else begin
      // Taken flag is seen while the delay slot issues; redirect follows it
      branch_taken <= go && is_bc && (cond_now == issue_instr[BR_TF_BIT]);
      branch_target <= issue_pc + XW'(4) + boff;
    end
  end

  // ----------------------------------------------------------------
  // Memory side of coprocessor loads and stores
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      mem_read <= 1'b0;
      mem_write <= 1'b0;
      mem_addr <= '0;
      mem_cop_reg <= '0;
      mem_unit <= '0;
    end else begin
      mem_read <= go && is_lwc;
      mem_write <= go && is_swc;
      mem_addr <= rs_value + simm;
      mem_cop_reg <= rt_f;
      mem_unit <= unit;
    end
  end

  // ----------------------------------------------------------------
  // Coprocessor unit port: moves and operations to units 1..3
  // ----------------------------------------------------------------
  logic ext_cop;
  assign ext_cop = go && is_cop && (unit != UNIT_SYSCTL) && !is_bc;

  always_ff @(posedge clock) begin
    if (reset) begin
      cop_valid <= 1'b0;
      cop_unit <= '0;
      cop_write <= 1'b0;
      cop_ctrl <= 1'b0;
      cop_func <= 1'b0;
      cop_reg <= '0;
      cop_wdata <= '0;
      cop_cofun <= '0;
    end else begin
      cop_valid <= ext_cop;
      cop_unit <= unit;
      cop_func <= issue_instr[CO_BIT];
      cop_write <= (rs_f == RS_MT) || (rs_f == RS_CT);
      cop_ctrl <= (rs_f == RS_CF) || (rs_f == RS_CT);
      cop_reg <= rd_f;
      cop_wdata <= rt_value;
      cop_cofun <= issue_instr[COFUN_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // System-control registers
  // ----------------------------------------------------------------
  logic [XW-1:0] index_reg;
  logic [XW-1:0] ent_hi;
  logic [XW-1:0] ent_lo;
  logic [XL_IDX_W-1:0] rnd;
  logic is_sc;
  logic sc_mt;
  logic sc_mf;
  logic xl_rd;
  logic xl_wi;
  logic xl_wr;
  logic xl_pr;
  logic xl_rfe;
  logic rd_pend;
  logic pr_pend;
  logic [XW-1:0] buf_hi;
  logic [XW-1:0] buf_lo;
  logic buf_hit;
  logic [XL_IDX_W-1:0] buf_idx;
  logic [XL_IDX_W-1:0] wr_slot;
  logic [XW-1:0] sc_rdata;

  assign is_sc = go && is_cop && (unit == UNIT_SYSCTL);
  assign sc_mt = is_sc && (rs_f == RS_MT);
  assign sc_mf = is_sc && (rs_f == RS_MF);
  assign xl_rd = is_sc && issue_instr[CO_BIT] && (fn_f == FN_XL_READ);
  assign xl_wi = is_sc && issue_instr[CO_BIT] && (fn_f == FN_XL_WRI);
  assign xl_wr = is_sc && issue_instr[CO_BIT] && (fn_f == FN_XL_WRR);
  assign xl_pr = is_sc && issue_instr[CO_BIT] && (fn_f == FN_XL_PROBE);
  assign xl_rfe = is_sc && issue_instr[CO_BIT] && (fn_f == FN_RESTORE);
  assign wr_slot = xl_wr ? rnd : index_reg[IDX_LO +: XL_IDX_W];

  ctx_xlate_buf u_buf (
    .clock(clock),
    .reset(reset),
    .wr_en(xl_wi || xl_wr),
    .wr_idx(wr_slot),
    .wr_hi(ent_hi),
    .wr_lo(ent_lo),
    .rd_idx(index_reg[IDX_LO +: XL_IDX_W]),
    .rd_hi(buf_hi),
    .rd_lo(buf_lo),
    .probe_hi(ent_hi),
    .probe_hit(buf_hit),
    .probe_idx(buf_idx)
  );

  always_ff @(posedge clock) begin
    if (reset) begin
      rd_pend <= 1'b0;
      pr_pend <= 1'b0;
    end else begin
      rd_pend <= xl_rd;
      pr_pend <= xl_pr;
    end
  end

  // Replacement pointer counts down each cycle and wraps above the wired floor
  always_ff @(posedge clock) begin
    if (reset) begin
      rnd <= RND_TOP;
    end else begin
      rnd <= (rnd == RND_FLOOR) ? RND_TOP : rnd - XL_IDX_W'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      index_reg <= '0;
    end else if (pr_pend) begin
      index_reg <= '0;
      index_reg[IDX_MISS_BIT] <= !buf_hit;
      index_reg[IDX_LO +: XL_IDX_W] <= buf_idx;
    end else if (sc_mt && rd_f == SC_INDEX) begin
      index_reg <= rt_value;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ent_hi <= '0;
      ent_lo <= '0;
    end else if (rd_pend) begin
      ent_hi <= buf_hi;
      ent_lo <= buf_lo;
    end else if (sc_mt && rd_f == SC_ENTHI) begin
      ent_hi <= rt_value;
    end else if (sc_mt && rd_f == SC_ENTLO) begin
      ent_lo <= rt_value;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      status <= STATUS_RST;
    end else if (xl_rfe) begin
      // Current <- previous, previous <- old; old pair is kept
      status[ST_SHIFT_LO-2 +: ST_KEEP_LO] <= status[ST_SHIFT_LO +: ST_KEEP_LO];
    end else if (sc_mt && rd_f == SC_STATUS) begin
      status <= rt_value;
    end
  end

  always_comb begin
    unique case (rd_f)
      SC_INDEX: sc_rdata = index_reg;
      SC_RANDOM: sc_rdata = {{(XW-RND_LO-XL_IDX_W){1'b0}}, rnd, {RND_LO{1'b0}}};
      SC_ENTHI: sc_rdata = ent_hi;
      SC_ENTLO: sc_rdata = ent_lo;
      SC_STATUS: sc_rdata = status;
      default: sc_rdata = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // General register write-back
  // ----------------------------------------------------------------
  logic mf_ext;
  assign mf_ext = go && is_cop && (unit != UNIT_SYSCTL) && !issue_instr[CO_BIT]
                  && ((rs_f == RS_MF) || (rs_f == RS_CF));

  always_ff @(posedge clock) begin
    if (reset) begin
      gpr_we <= 1'b0;
      gpr_waddr <= '0;
      gpr_wdata <= '0;
    end else begin
      gpr_we <= sc_mf || mf_ext;
      gpr_waddr <= rt_f;
      // Unit data arrives in the issue cycle on cop_rdata, from the bank of the unit the issue names
      gpr_wdata <= sc_mf ? sc_rdata : cop_rdata;
    end
  end
endmodule

// ### ctx_exec_monitor.sv
// Checker for the trap, coprocessor and system-control executor.
// Assumes it is bound to ctx_exec and sees only that module's ports.
module ctx_exec_monitor (
  input wire logic clock,
  input wire logic reset,
  input wire logic issue_valid,
  input wire logic [ctx_pkg::XW-1:0] issue_instr,
  input wire logic [ctx_pkg::XW-1:0] issue_pc,
  input wire logic [ctx_pkg::XW-1:0] rs_value,
  input wire logic [ctx_pkg::XW-1:0] rt_value,
  input wire logic [3:0] branch_condition_inputs,
  input wire logic [ctx_pkg::XW-1:0] cop_rdata,
  input wire logic trap_valid,
  input wire ctx_pkg::ctx_trap_e trap_kind,
  input wire logic [ctx_pkg::XW-1:0] trap_epc,
  input wire logic branch_taken,
  input wire logic [ctx_pkg::XW-1:0] branch_target,
  input wire logic gpr_we,
  input wire logic [4:0] gpr_waddr,
  input wire logic [ctx_pkg::XW-1:0] gpr_wdata,
  input wire logic mem_read,
  input wire logic mem_write,
  input wire logic [ctx_pkg::XW-1:0] mem_addr,
  input wire logic cop_valid,
  input wire logic [1:0] cop_unit,
  input wire logic cop_write,
  input wire logic cop_ctrl,
  input wire logic cop_func,
  input wire logic [ctx_pkg::XW-1:0] cop_wdata,
  input wire logic [ctx_pkg::COFUN_W-1:0] cop_cofun,
  input wire logic [ctx_pkg::XW-1:0] status
);
  import ctx_pkg::*;
  // ----------------------------------------
  // Issue decode seen at the ports
  // ----------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic take, hit;
  logic [5:0] op;
  logic [4:0] rs, rt;
  logic [31:0] off, ea, tgt, exception_return_restore;
  // Pins pass a synchroniser in the executor; judge a branch only on settled lines
  logic [3:0] cond_prev;
  logic [2:0] cond_age;
  always_ff @(posedge clock) begin
    cond_prev <= branch_condition_inputs;
    if (reset || branch_condition_inputs != cond_prev) begin
      cond_age <= '0;
    end else if (cond_age != 3'h7) begin
      cond_age <= cond_age + 3'h1;
    end
  end
  // The issue right after a trap is squashed, so it is no cause
  assign take = issue_valid && !trap_valid;
  assign op = issue_instr[OP_HI:OP_LO];
  assign rs = issue_instr[RS_HI:RS_LO];
  assign rt = issue_instr[RT_HI:RT_LO];
  assign off = {{16{issue_instr[15]}}, issue_instr[15:0]};
  assign ea = rs_value + off;
  assign tgt = issue_pc + 32'h4 + {off[29:0], 2'b00};
  assign hit = cond_prev[op[1:0]] == issue_instr[BR_TF_BIT];
  assign exception_return_restore = {status[31:4], status[5:2]};
  a_trap_raised: assert property (take && op == OP_SPECIAL && issue_instr[5:1] == 5'h06 |=>
    trap_valid && trap_epc == $past(issue_pc)
    && trap_kind == ($past(issue_instr[0]) ? CTX_TRAP_BREAK : CTX_TRAP_OS_SERVICE_TRAP_INSTR))
    else $error("trap not raised as issued");
  a_trap_rtype_only: assert property (take && op != OP_SPECIAL |=> !trap_valid)
    else $error("trap from a non register-type word");
  a_trap_precise: assert property (trap_valid |=>
    !(gpr_we || mem_read || mem_write || cop_valid || branch_taken || trap_valid))
    else $error("state changed after a trap");
  a_load_address: assert property (take && op[5:2] == OP_LWC_HI && !op[1] |=>
    mem_read && !mem_write && mem_addr == $past(ea)) else $error("load address wrong");
  a_store_address: assert property (take && op[5:2] == OP_SWC_HI && !op[1] |=>
    mem_write && !mem_read && mem_addr == $past(ea)) else $error("store address wrong");
  a_move_from_unit: assert property (take && op == {OP_COP_HI, UNIT_FPU}
    && (rs == RS_MF || rs == RS_CF) |=> gpr_we && gpr_waddr == $past(rt)
    && gpr_wdata == $past(cop_rdata)) else $error("move from unit wrong");
  a_move_to_unit: assert property (take && op == {OP_COP_HI, UNIT_FPU}
    && (rs == RS_MT || rs == RS_CT) |=> cop_valid && cop_write && cop_unit == UNIT_FPU
    && cop_ctrl == ($past(rs) == RS_CT) && cop_wdata == $past(rt_value))
    else $error("move to unit wrong");
  a_unit_operation: assert property (take && op == {OP_COP_HI, UNIT_FPU} && issue_instr[CO_BIT]
    |=> cop_valid && cop_func && cop_cofun == $past(issue_instr[24:0]) && !gpr_we && !mem_write)
    else $error("unit operation wrong");
  a_cond_branch: assert property (take && op[5:2] == OP_COP_HI && rs == RS_BC
    && cond_age >= 3'h4 |=>
    branch_taken == $past(hit) && (!branch_taken || branch_target == $past(tgt)))
    else $error("condition branch wrong");
  a_restore_status: assert property (take && op == {OP_COP_HI, UNIT_SYSCTL}
    && issue_instr[CO_BIT] && issue_instr[5:0] == FN_RESTORE |=> status == $past(exception_return_restore))
    else $error("status restore wrong");
  c_trap: cover property (trap_valid);
  c_branch: cover property (branch_taken);
  c_store: cover property (mem_write);
endmodule
bind ctx_exec ctx_exec_monitor i_mon (.*);

// ### ctx_pkg.sv
// Package for the coprocessor and trap instruction executor.
// Assumes a 32-bit instruction word issued one per cycle by the integer pipeline.
package ctx_pkg;
  localparam int XW = 32;
  localparam int OP_HI = 31;
  localparam int OP_LO = 26;
  localparam int RS_HI = 25;
  localparam int RS_LO = 21;
  localparam int RT_HI = 20;
  localparam int RT_LO = 16;
  localparam int RD_HI = 15;
  localparam int RD_LO = 11;
  localparam int FN_HI = 5;
  localparam int FN_LO = 0;
  localparam int IMM_W = 16;
  localparam int COFUN_W = 25;
  localparam int CO_BIT = 25;
  localparam int BR_TF_BIT = 16;
  localparam int UNIT_HI = 27;
  localparam int UNIT_LO = 26;
  localparam logic [5:0] OP_SPECIAL = 6'h00;
  localparam logic [5:0] OP_COP = 6'h04;
  localparam logic [5:0] OP_LWC = 6'h0c;
  localparam logic [5:0] OP_SWC = 6'h0e;
  localparam logic [3:0] OP_COP_HI = 4'h4;
  localparam logic [3:0] OP_LWC_HI = 4'hc;
  localparam logic [3:0] OP_SWC_HI = 4'he;
  localparam logic [5:0] FN_OS_SERVICE_TRAP_INSTR = 6'h0c;
  localparam logic [5:0] FN_BREAK = 6'h0d;
  localparam logic [4:0] RS_MF = 5'h00;
  localparam logic [4:0] RS_CF = 5'h02;
  localparam logic [4:0] RS_MT = 5'h04;
  localparam logic [4:0] RS_CT = 5'h06;
  localparam logic [4:0] RS_BC = 5'h08;
  localparam logic [5:0] FN_XL_READ = 6'h01;
  localparam logic [5:0] FN_XL_WRI = 6'h02;
  localparam logic [5:0] FN_XL_WRR = 6'h06;
  localparam logic [5:0] FN_XL_PROBE = 6'h08;
  localparam logic [5:0] FN_RESTORE = 6'h10;
  localparam logic [1:0] UNIT_SYSCTL = 2'h0;
  localparam logic [1:0] UNIT_FPU = 2'h1;
  localparam int XL_ENTRIES = 64;
  localparam int XL_IDX_W = 6;
  localparam int IDX_MISS_BIT = 31;
  localparam int IDX_LO = 8;
  localparam int RND_LO = 8;
  localparam logic [XL_IDX_W-1:0] RND_FLOOR = 6'h08;
  localparam logic [XL_IDX_W-1:0] RND_TOP = 6'h3f;
  localparam logic [4:0] SC_INDEX = 5'h00;
  localparam logic [4:0] SC_RANDOM = 5'h01;
  localparam logic [4:0] SC_ENTLO = 5'h02;
  localparam logic [4:0] SC_ENTHI = 5'h0a;
  localparam logic [4:0] SC_STATUS = 5'h0c;
  localparam int ST_HIST_W = 6;
  localparam int ST_KEEP_LO = 4;
  localparam int ST_SHIFT_LO = 2;
  localparam int HI_MATCH_LO = 6;
  localparam logic [XW-1:0] STATUS_RST = 32'h00000000;
  typedef enum logic [1:0] {CTX_TRAP_NONE, CTX_TRAP_OS_SERVICE_TRAP_INSTR, CTX_TRAP_BREAK} ctx_trap_e;
endpackage

// ### ctx_xlate_buf.sv
// Translation buffer storage with read, write and probe ports.
// Assumes one command per cycle; results are registered.
module ctx_xlate_buf (
  input wire logic clock,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic [ctx_pkg::XL_IDX_W-1:0] wr_idx,
  input wire logic [ctx_pkg::XW-1:0] wr_hi,
  input wire logic [ctx_pkg::XW-1:0] wr_lo,
  input wire logic [ctx_pkg::XL_IDX_W-1:0] rd_idx,
  output logic [ctx_pkg::XW-1:0] rd_hi,
  output logic [ctx_pkg::XW-1:0] rd_lo,
  input wire logic [ctx_pkg::XW-1:0] probe_hi,
  output logic probe_hit,
  output logic [ctx_pkg::XL_IDX_W-1:0] probe_idx
);
  import ctx_pkg::*;
  logic [XW-1:0] mem_hi [XL_ENTRIES];
  logic [XW-1:0] mem_lo [XL_ENTRIES];
  logic hit_c;
  logic [XL_IDX_W-1:0] idx_c;

  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem_hi[wr_idx] <= wr_hi;
      mem_lo[wr_idx] <= wr_lo;
    end
  end

  always_ff @(posedge clock) begin
    rd_hi <= mem_hi[rd_idx];
    rd_lo <= mem_lo[rd_idx];
  end

  // Lowest matching slot wins; a multiple match is a software error
  always_comb begin
    hit_c = 1'b0;
    idx_c = '0;
    for (int i = XL_ENTRIES - 1; i >= 0; i--) begin
      if (mem_hi[i][XW-1:HI_MATCH_LO] == probe_hi[XW-1:HI_MATCH_LO]) begin
        hit_c = 1'b1;
        idx_c = XL_IDX_W'(i);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      probe_hit <= 1'b0;
      probe_idx <= '0;
    end else begin
      probe_hit <= hit_c;
      probe_idx <= idx_c;
    end
  end
endmodule

// ### tb_coprocessor_trap_instruction_exec.sv
// Self-checking bench for ctx_exec with a coprocessor model on the far side.
// Assumes the checker is bound to ctx_exec by its own file.
module tb_coprocessor_trap_instruction_exec;
  timeunit 1ns;
  timeprecision 1ps;
  import ctx_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic issue_valid = 1'b0;
  logic [31:0] issue_instr = '0, issue_pc = '0, rs_value = '0, rt_value = '0;
  logic [3:0] cond_set = '0, branch_condition_inputs;
  logic trap_valid, branch_taken, gpr_we, mem_read, mem_write, cop_valid, cop_write;
  logic cop_ctrl, cop_func;
  ctx_trap_e trap_kind;
  logic [31:0] trap_epc, branch_target, gpr_wdata, mem_addr, cop_wdata, status, cop_rdata;
  logic [4:0] gpr_waddr, mem_cop_reg, cop_reg;
  logic [1:0] mem_unit, cop_unit;
  logic [24:0] cop_cofun;
  int errors = 0, checks_done = 0;
  ctx_exec i_dut (.*);
  ctx_cop_model i_cop (.*);
  initial forever #20 clock = ~clock;
  // ----------------------------------------
  // Shared drivers
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] ins(logic [5:0] o, logic [4:0] s, logic [4:0] t,
                                      logic [15:0] l);
    return {o, s, t, l};
  endfunction
  task automatic iss(input logic [31:0] i, input logic [31:0] a, input logic [31:0] b);
    @(posedge clock);
    issue_valid <= 1'b1;
    issue_instr <= i;
    rs_value <= a;
    rt_value <= b;
    @(posedge clock);
    issue_valid <= 1'b0;
    #1;
  endtask
  task automatic mt0(input logic [4:0] r, input logic [31:0] v);
    iss(ins(6'h10, RS_MT, 5'h0, {r, 11'h0}), '0, v);
  endtask
  task automatic mf0(input logic [4:0] r);
    iss(ins(6'h10, RS_MF, 5'h7, {r, 11'h0}), '0, '0);
  endtask
  task automatic xl(input logic [5:0] f);
    iss(ins(6'h10, 5'h10, 5'h0, {10'h0, f}), '0, '0);
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_trap();
    @(posedge clock);
    issue_valid <= 1'b1;
    issue_pc <= 32'h100;
    issue_instr <= {26'h0, FN_OS_SERVICE_TRAP_INSTR};
    @(posedge clock);
    issue_instr <= ins(6'h10, RS_MT, 5'h0, {SC_STATUS, 11'h0});
    rt_value <= 32'hff;
    #1;
    chk(trap_valid, 1);
    chk(trap_kind, CTX_TRAP_OS_SERVICE_TRAP_INSTR);
    chk(trap_epc, 32'h100);
    @(posedge clock);
    issue_valid <= 1'b0;
    #1;
    chk(status, STATUS_RST);
    iss({6'h0, 20'hfffff, FN_BREAK}, '0, '0);
    chk(trap_kind, CTX_TRAP_BREAK);
    iss({6'h0d, 20'h0, FN_OS_SERVICE_TRAP_INSTR}, '0, '0);
    chk(trap_valid, 0);
    $display("trap test done");
  endtask
  task automatic t_mem();
    for (int z = 0; z < 2; z++) begin
      iss(ins({4'hc, 2'(z)}, 5'h1, 5'h9, 16'hfff8), 32'h1000, '0);
      chk(mem_read, 1);
      chk(mem_addr, 32'h0ff8);
      chk(mem_unit, z);
      iss(ins({4'he, 2'(z)}, 5'h1, 5'h9, 16'h0010), 32'h1000, '0);
      chk(mem_write, 1);
      chk(mem_addr, 32'h1010);
      chk(mem_cop_reg, 9);
    end
    $display("memory test done");
  endtask
  task automatic t_cop();
    iss(ins(6'h11, RS_MT, 5'h2, {5'h3, 11'h0}), '0, 32'ha5a50001);
    chk(cop_valid & cop_write & ~cop_ctrl, 1);
    chk(cop_reg, 3);
    chk(cop_unit, UNIT_FPU);
    iss(ins(6'h11, RS_CT, 5'h2, {5'h3, 11'h0}), '0, 32'h5a5a0002);
    chk(cop_ctrl, 1);
    iss(ins(6'h11, RS_MF, 5'h4, {5'h3, 11'h0}), '0, '0);
    chk(gpr_wdata, 32'ha5a50001);
    chk(gpr_waddr, 4);
    iss(ins(6'h11, RS_CF, 5'h4, {5'h3, 11'h0}), '0, '0);
    chk(gpr_wdata, 32'h5a5a0002);
    iss({6'h11, 1'b1, 25'h1abcdef}, '0, '0);
    chk(cop_func & ~gpr_we & ~mem_write, 1);
    chk(cop_cofun, 25'h1abcdef);
    $display("coprocessor test done");
  endtask
  task automatic t_branch();
    // Every unit, both variants, both line levels; other lines opposite
    for (int k = 0; k < 16; k++) begin
      @(posedge clock);
      cond_set <= k[3] ? 4'h1 << k[1:0] : ~(4'h1 << k[1:0]);
      issue_pc <= 32'h2000;
      // Lines pass the executor's synchroniser; give them time to settle
      repeat (4) @(posedge clock);
      iss({4'h4, k[1:0], RS_BC, 4'h0, k[2], 16'hfffe}, '0, '0);
      chk(branch_taken, k[3] == k[2]);
      if (k[3] == k[2]) chk(branch_target, 32'h1ffc);
    end
    $display("branch test done");
  endtask
  task automatic t_sysctl();
    mt0(SC_STATUS, 32'h24);
    chk(status, 32'h24);
    xl(FN_RESTORE);
    chk(status, 32'h29);
    mf0(SC_STATUS);
    chk(gpr_wdata, 32'h29);
    $display("system control test done");
  endtask
  task automatic t_xlate();
    for (int i = 0; i < 64; i++) begin
      mt0(SC_INDEX, i << 8);
      mt0(SC_ENTHI, (i + 1) << 12);
      mt0(SC_ENTLO, i);
      xl(FN_XL_WRI);
    end
    mt0(SC_INDEX, 32'h900);
    xl(FN_XL_READ);
    @(posedge clock);
    mf0(SC_ENTHI);
    chk(gpr_wdata, 32'ha000);
    mf0(SC_ENTLO);
    chk(gpr_wdata, 32'h9);
    mt0(SC_ENTHI, 32'h5000);
    xl(FN_XL_PROBE);
    @(posedge clock);
    mf0(SC_INDEX);
    chk(gpr_wdata, 32'h400);
    mt0(SC_ENTHI, 32'hfff00000);
    xl(FN_XL_PROBE);
    @(posedge clock);
    mf0(SC_INDEX);
    chk(gpr_wdata[31], 1);
    mt0(SC_ENTHI, 32'h77777000);
    xl(FN_XL_WRR);
    xl(FN_XL_PROBE);
    @(posedge clock);
    mf0(SC_INDEX);
    chk(!gpr_wdata[31] && gpr_wdata[13:8] >= 8, 1);
    $display("translation test done");
  endtask
  initial begin
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    t_trap();
    t_mem();
    t_cop();
    t_branch();
    t_sysctl();
    t_xlate();
    complete_run();
  end
  // Whole run needs about seven hundred cycles
  initial begin
    repeat (5000) @(posedge clock);
    errors++;
    complete_run();
  end
endmodule
